// ---- core/adcp_pkg.sv ----
// Purpose: shared constants, types and helpers of the converter power and coding control
// Assumes: core clock of 200 MHz, 12-bit result, 4-bit byte address on the register port
// Notes: register offsets are byte addresses, one 32-bit word each, data in the low bits
package adcp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_RESULT = 4'h8;

    // ------------------------------------------------------------
    // control byte fields
    // ------------------------------------------------------------
    localparam int CTRL_PD_LO = 0;
    localparam int CTRL_PD_HI = 1;
    localparam int CTRL_BIP = 2;
    localparam int CTRL_RNG = 3;
    localparam int CTRL_CH_LSB = 4;
    localparam int CTRL_CH_MSB = 6;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------
    // status fields and reset values
    // ------------------------------------------------------------
    localparam int STAT_PWR_LSB = 0;
    localparam int STAT_CONV_LSB = 2;
    localparam int STAT_SHUTDOWN_PIN_N = 4;
    localparam logic [11:0] RESULT_RESET = 12'h000;

    // ------------------------------------------------------------
    // link address and timing
    // ------------------------------------------------------------
    localparam logic [3:0] SLAVE_ADDR_HI = 4'h5;
    localparam int unsigned CORE_CLK_KHZ = 200000;
    localparam int unsigned CONV_CLK_KHZ = 1560;
    // conversion clock period in core cycles, rounded down to keep the rate at or above spec
    localparam int unsigned CONV_DIV_CYCLES = CORE_CLK_KHZ / CONV_CLK_KHZ;
    localparam int unsigned CONV_STEPS = 12;
    // address byte ends on the eighth link clock rise, the waking bit is the ninth
    localparam logic [3:0] ADDR_BIT_LAST = 4'h7;
    localparam logic [3:0] WAKE_BIT = 4'h8;
    localparam logic LINK_WR = 1'h0;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ADCP_PWR_NORMAL = 2'h0,
        ADCP_PWR_STANDBY = 2'h1,
        ADCP_PWR_FULL = 2'h2
    } adcp_pwr_t;

    typedef enum logic [1:0] {
        ADCP_CONV_IDLE = 2'h0,
        ADCP_CONV_ACQ = 2'h1,
        ADCP_CONV_RUN = 2'h2
    } adcp_conv_t;

    function automatic adcp_pwr_t pd_decode(input logic pd_hi, input logic pd_lo);
        if (!pd_hi) begin
            pd_decode = ADCP_PWR_NORMAL;
        end else if (!pd_lo) begin
            pd_decode = ADCP_PWR_STANDBY;
        end else begin
            pd_decode = ADCP_PWR_FULL;
        end
    endfunction : pd_decode

    // raw sample is offset binary; bipolar turns it into two's complement
    function automatic logic [11:0] code_result(input logic [11:0] raw, input logic bipolar_select);
        code_result = bipolar_select ? {~raw[11], raw[10:0]} : raw;
    endfunction : code_result

endpackage : adcp_pkg

// ---- core/adcp_link_mon.sv ----
// Purpose: watches the two-wire link pins for start, stop and a write to our address
// Assumes: pins come from outside the core clock domain; the link clock is far slower
// Notes: only tracks framing; the byte protocol engine lives elsewhere
`timescale 1ns/100ps

// ------------------------------------------------------------
// events passed from the monitor to the control core
// ------------------------------------------------------------
interface adcp_link_if;
    logic start_evt;
    logic stop_evt;
    logic wake_evt;
    modport mon (output start_evt, output stop_evt, output wake_evt);
    modport ctl (input start_evt, input stop_evt, input wake_evt);
endinterface : adcp_link_if

module adcp_link_mon (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] addr_pin_i,
    adcp_link_if.mon evt
);

    // ------------------------------------------------------------
    // synchronisers
    // ------------------------------------------------------------
    logic [1:0] scl_meta_ff, sda_meta_ff;
    logic [2:0] addr_meta_ff, addr_sync_ff;
    logic scl_sync_ff, sda_sync_ff, scl_prev_ff, sda_prev_ff;
    logic active_ff, nxt_active, armed_ff, nxt_armed, wake_ff, nxt_wake;
    logic [3:0] bit_cnt_ff, nxt_bit_cnt;
    logic [6:0] shift_ff, nxt_shift;
    logic scl_rise, start_det, stop_det;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            scl_meta_ff <= 2'h3;
            sda_meta_ff <= 2'h3;
            addr_meta_ff <= 3'h0;
            addr_sync_ff <= 3'h0;
            scl_sync_ff <= 1'h1;
            sda_sync_ff <= 1'h1;
            scl_prev_ff <= 1'h1;
            sda_prev_ff <= 1'h1;
        end else begin
            scl_meta_ff <= {scl_meta_ff[0], scl_i};
            sda_meta_ff <= {sda_meta_ff[0], sda_i};
            addr_meta_ff <= addr_pin_i;
            addr_sync_ff <= addr_meta_ff;
            scl_sync_ff <= scl_meta_ff[1];
            sda_sync_ff <= sda_meta_ff[1];
            scl_prev_ff <= scl_sync_ff;
            sda_prev_ff <= sda_sync_ff;
        end
    end

    assign scl_rise = scl_sync_ff && !scl_prev_ff;
    assign start_det = scl_sync_ff && scl_prev_ff && sda_prev_ff && !sda_sync_ff;
    assign stop_det = scl_sync_ff && scl_prev_ff && !sda_prev_ff && sda_sync_ff;

    // ------------------------------------------------------------
    // address byte tracking
    // ------------------------------------------------------------
    always_comb begin
        nxt_active = active_ff;
        nxt_armed = armed_ff;
        nxt_bit_cnt = bit_cnt_ff;
        nxt_shift = shift_ff;
        nxt_wake = 1'h0;
        if (start_det) begin
            nxt_active = 1'h1;
            nxt_armed = 1'h0;
            nxt_bit_cnt = 4'h0;
            nxt_shift = 7'h00;
        end else if (stop_det) begin
            nxt_active = 1'h0;
            nxt_armed = 1'h0;
        end else if (scl_rise && active_ff) begin
            nxt_shift = {shift_ff[5:0], sda_sync_ff};
            nxt_bit_cnt = bit_cnt_ff + 4'h1;
            if (bit_cnt_ff == adcp_pkg::ADDR_BIT_LAST) begin
                nxt_armed = ({shift_ff, sda_sync_ff}
                             == {adcp_pkg::SLAVE_ADDR_HI, addr_sync_ff, adcp_pkg::LINK_WR});
                nxt_active = nxt_armed;
            end else if (bit_cnt_ff == adcp_pkg::WAKE_BIT) begin
                nxt_wake = armed_ff;
                nxt_active = 1'h0;
                nxt_armed = 1'h0;
            end
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            active_ff <= 1'h0;
            armed_ff <= 1'h0;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 7'h00;
            wake_ff <= 1'h0;
        end else begin
            active_ff <= nxt_active;
            armed_ff <= nxt_armed;
            bit_cnt_ff <= nxt_bit_cnt;
            shift_ff <= nxt_shift;
            wake_ff <= nxt_wake;
        end
    end

    assign evt.start_evt = start_det;
    assign evt.stop_evt = stop_det;
    assign evt.wake_evt = wake_ff;

endmodule : adcp_link_mon

// ---- core/adcp_power_ctrl.sv ----
// Purpose: power-down modes, conversion sequencing and result coding of the converter
// Assumes: raw_sample_i is offset binary from the converter core, stable when sampled
// Notes: control byte written over the register port; link pins only frame and wake
//
// Function
// - two select bits of the control byte choose standby or full power-down
// - software power-down waits until the running conversion has finished
// - register reads and the stored result stay available in every power mode
// - addressed write on the link wakes the device after the following bit
// - shutdown pin low forces full power-down at once and aborts conversion
// - standby keeps bandgap and reference buffer enabled
// - full power-down keeps only the bandgap enabled
// - standby in each control byte gives auto-shutdown after every conversion
// - unipolar results straight binary, bipolar results two's complement, 4096 steps
// - upper bit clear normal, upper set lower clear standby, both set full
// - acquisition from control byte latch to stop, then convert at 1.56MHz
// - reset starts in normal mode with control and result registers cleared
//
// Local design decisions: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps

module adcp_power_ctrl #(
    parameter int unsigned CONV_DIV = adcp_pkg::CONV_DIV_CYCLES,
    parameter int unsigned STEPS = adcp_pkg::CONV_STEPS
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    output logic [31:0] rd_data_o,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic [2:0] addr_pin_i,
    input wire logic shutdown_pin_n,
    input wire logic [11:0] raw_sample_i,
    output logic [2:0] channel_sel_o,
    output logic range_select_o,
    output logic bipolar_select_o,
    output logic acquire_o,
    output logic convert_busy_o,
    output logic standby_power_down_o,
    output logic full_power_down_o,
    output logic bandgap_en_o,
    output logic ref_buffer_en_o,
    output logic analog_en_o
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (CONV_DIV < 2 || CONV_DIV > 255) begin : g_bad_div
        $error("CONV_DIV out of range");
    end
    if (STEPS < 1 || STEPS > 15) begin : g_bad_steps
        $error("STEPS out of range");
    end

    localparam logic [7:0] DIV_LAST = 8'(CONV_DIV - 1);
    localparam logic [3:0] STEP_LAST = 4'(STEPS - 1);

    // ------------------------------------------------------------
    // link monitor
    // ------------------------------------------------------------
    adcp_link_if link_evt ();

    adcp_link_mon u_link_mon (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .addr_pin_i(addr_pin_i),
        .evt(link_evt.mon)
    );

    // ------------------------------------------------------------
    // shutdown pin synchroniser
    // ------------------------------------------------------------
    logic shutdown_pin_n_meta_ff, shutdown_pin_n_sync_ff;

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            shutdown_pin_n_meta_ff <= 1'h1;
            shutdown_pin_n_sync_ff <= 1'h1;
        end else begin
            shutdown_pin_n_meta_ff <= shutdown_pin_n;
            shutdown_pin_n_sync_ff <= shutdown_pin_n_meta_ff;
        end
    end

    // ------------------------------------------------------------
    // power and conversion state
    // ------------------------------------------------------------
    adcp_pkg::adcp_pwr_t pwr_ff, nxt_pwr;
    adcp_pkg::adcp_conv_t conv_ff, nxt_conv;
    logic [7:0] ctrl_ff, nxt_ctrl;
    logic [11:0] result_ff, nxt_result;
    logic [7:0] div_cnt_ff, nxt_div_cnt;
    logic [3:0] step_cnt_ff, nxt_step_cnt;
    logic hw_sd_ff, nxt_hw_sd;
    logic ctrl_wr;

    assign ctrl_wr = wr_en_i && (addr_i == adcp_pkg::REG_CTRL);

    always_comb begin
        nxt_pwr = pwr_ff;
        nxt_conv = conv_ff;
        nxt_ctrl = ctrl_ff;
        nxt_result = result_ff;
        nxt_div_cnt = div_cnt_ff;
        nxt_step_cnt = step_cnt_ff;
        nxt_hw_sd = hw_sd_ff;
        if (!shutdown_pin_n_sync_ff) begin
            nxt_pwr = adcp_pkg::ADCP_PWR_FULL;
            nxt_conv = adcp_pkg::ADCP_CONV_IDLE;
            nxt_div_cnt = 8'h00;
            nxt_step_cnt = 4'h0;
            nxt_hw_sd = 1'h1;
        end else if (hw_sd_ff) begin
            nxt_pwr = adcp_pkg::ADCP_PWR_NORMAL;
            nxt_hw_sd = 1'h0;
        end else begin
            if (link_evt.wake_evt) begin
                nxt_pwr = adcp_pkg::ADCP_PWR_NORMAL;
            end
            case (conv_ff)
                adcp_pkg::ADCP_CONV_IDLE: begin
                    if (ctrl_wr) begin
                        nxt_ctrl = wr_data_i[7:0];
                        nxt_conv = adcp_pkg::ADCP_CONV_ACQ;
                    end
                end
                adcp_pkg::ADCP_CONV_ACQ: begin
                    if (link_evt.stop_evt) begin
                        nxt_conv = adcp_pkg::ADCP_CONV_RUN;
                        nxt_div_cnt = 8'h00;
                        nxt_step_cnt = 4'h0;
                    end
                end
                adcp_pkg::ADCP_CONV_RUN: begin
                    if (div_cnt_ff == DIV_LAST) begin
                        nxt_div_cnt = 8'h00;
                        nxt_step_cnt = step_cnt_ff + 4'h1;
                        if (step_cnt_ff == STEP_LAST) begin
                            nxt_result = adcp_pkg::code_result(raw_sample_i,
                                                               ctrl_ff[adcp_pkg::CTRL_BIP]);
                            nxt_conv = adcp_pkg::ADCP_CONV_IDLE;
                            nxt_pwr = adcp_pkg::pd_decode(ctrl_ff[adcp_pkg::CTRL_PD_HI],
                                                          ctrl_ff[adcp_pkg::CTRL_PD_LO]);
                        end
                    end else begin
                        nxt_div_cnt = div_cnt_ff + 8'h01;
                    end
                end
                default: begin
                    nxt_conv = adcp_pkg::ADCP_CONV_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            pwr_ff <= adcp_pkg::ADCP_PWR_NORMAL;
            conv_ff <= adcp_pkg::ADCP_CONV_IDLE;
            ctrl_ff <= adcp_pkg::CTRL_RESET;
            result_ff <= adcp_pkg::RESULT_RESET;
            div_cnt_ff <= 8'h00;
            step_cnt_ff <= 4'h0;
            hw_sd_ff <= 1'h0;
        end else begin
            pwr_ff <= nxt_pwr;
            conv_ff <= nxt_conv;
            ctrl_ff <= nxt_ctrl;
            result_ff <= nxt_result;
            div_cnt_ff <= nxt_div_cnt;
            step_cnt_ff <= nxt_step_cnt;
            hw_sd_ff <= nxt_hw_sd;
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    logic [31:0] rd_data_ff, nxt_rd_data;

    // reads never gated by power mode
    always_comb begin
        nxt_rd_data = 32'h0000_0000;
        if (rd_en_i) begin
            case (addr_i)
                adcp_pkg::REG_CTRL: begin
                    nxt_rd_data[7:0] = ctrl_ff;
                end
                adcp_pkg::REG_STATUS: begin
                    nxt_rd_data[adcp_pkg::STAT_PWR_LSB +: 2] = pwr_ff;
                    nxt_rd_data[adcp_pkg::STAT_CONV_LSB +: 2] = conv_ff;
                    nxt_rd_data[adcp_pkg::STAT_SHUTDOWN_PIN_N] = !shutdown_pin_n_sync_ff;
                end
                adcp_pkg::REG_RESULT: begin
                    nxt_rd_data[11:0] = result_ff;
                end
                default: begin
                    nxt_rd_data = 32'h0000_0000;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rd_data_ff <= 32'h0000_0000;
        end else begin
            rd_data_ff <= nxt_rd_data;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign rd_data_o = rd_data_ff;
    assign channel_sel_o = ctrl_ff[adcp_pkg::CTRL_CH_MSB:adcp_pkg::CTRL_CH_LSB];
    assign range_select_o = ctrl_ff[adcp_pkg::CTRL_RNG];
    assign bipolar_select_o = ctrl_ff[adcp_pkg::CTRL_BIP];
    assign acquire_o = (conv_ff == adcp_pkg::ADCP_CONV_ACQ);
    assign convert_busy_o = (conv_ff == adcp_pkg::ADCP_CONV_RUN);
    assign standby_power_down_o = (pwr_ff == adcp_pkg::ADCP_PWR_STANDBY);
    assign full_power_down_o = (pwr_ff == adcp_pkg::ADCP_PWR_FULL);
    // bandgap always on, buffer off only in full
    assign bandgap_en_o = 1'h1;
    assign ref_buffer_en_o = (pwr_ff != adcp_pkg::ADCP_PWR_FULL);
    assign analog_en_o = (pwr_ff == adcp_pkg::ADCP_PWR_NORMAL);

endmodule : adcp_power_ctrl

// ---- testbench/adcp_power_ctrl_checker.sv ----
// Purpose: port-level checks of the converter power-down and coding control
// Assumes: one core clock domain, bound to adcp_power_ctrl
// Notes: aborted conversions are left out of the length check
`timescale 1ns/100ps

module adcp_power_ctrl_checker #(
    parameter int unsigned CONV_DIV = adcp_pkg::CONV_DIV_CYCLES,
    parameter int unsigned STEPS = adcp_pkg::CONV_STEPS
) (
    input wire logic core_clk_i,
    input wire logic reset_n_i,
    input wire logic [3:0] addr_i,
    input wire logic wr_en_i,
    input wire logic rd_en_i,
    input wire logic [31:0] rd_data_o,
    input wire logic shutdown_pin_n,
    input wire logic acquire_o,
    input wire logic convert_busy_o,
    input wire logic standby_power_down_o,
    input wire logic full_power_down_o,
    input wire logic bandgap_en_o,
    input wire logic ref_buffer_en_o,
    input wire logic analog_en_o
);
    localparam int CONV_CYC = CONV_DIV * STEPS;
    logic [15:0] busy_cnt_ff;
    logic [15:0] nxt_busy_cnt;

    // ------------------------------------------------------------
    // conversion length counter
    // ------------------------------------------------------------
    always_comb begin
        nxt_busy_cnt = convert_busy_o ? busy_cnt_ff + 16'h1 : 16'h0;
    end

    always_ff @(posedge core_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            busy_cnt_ff <= 16'h0;
        end else begin
            busy_cnt_ff <= nxt_busy_cnt;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence shutdown_pin_n_fall_s;
        $fell(shutdown_pin_n);
    endsequence

    // pin still high excludes the abort case
    sequence conv_end_s;
        $fell(convert_busy_o) && shutdown_pin_n;
    endsequence

    chk_full_ref_off: assert property (full_power_down_o |-> !ref_buffer_en_o)
        else $error("reference buffer on in full power-down");
    chk_stby_refs_on: assert property (standby_power_down_o
        |-> bandgap_en_o && ref_buffer_en_o)
        else $error("reference off in standby");
    chk_bandgap_on: assert property (bandgap_en_o)
        else $error("bandgap disabled");
    chk_pd_hold_conv: assert property (convert_busy_o && $past(convert_busy_o)
        && shutdown_pin_n |-> $stable(standby_power_down_o) && $stable(full_power_down_o))
        else $error("power mode changed during conversion");
    chk_shutdown_pin_n_enter: assert property (shutdown_pin_n_fall_s |-> ##[1:5] full_power_down_o)
        else $error("shutdown pin did not force full power-down");
    chk_shutdown_pin_n_abort: assert property (shutdown_pin_n_fall_s
        |-> ##[1:5] (!convert_busy_o && !acquire_o))
        else $error("conversion not aborted by shutdown");
    chk_rd_idle_zero: assert property (!$past(rd_en_i) |-> rd_data_o == 32'h0)
        else $error("read data outside its cycle");
    chk_mode_excl: assert property (!(standby_power_down_o && full_power_down_o)
        && analog_en_o == !(standby_power_down_o || full_power_down_o))
        else $error("power mode decode inconsistent");
    chk_acq_cause: assert property ($rose(acquire_o)
        |-> $past(wr_en_i) && $past(addr_i) == adcp_pkg::REG_CTRL)
        else $error("acquisition without control write");
    chk_acq_to_conv: assert property ($fell(acquire_o) && shutdown_pin_n
        |-> convert_busy_o)
        else $error("conversion did not follow acquisition");
    chk_conv_length: assert property (conv_end_s
        |-> busy_cnt_ff >= CONV_CYC && busy_cnt_ff <= CONV_CYC + 2)
        else $error("conversion length wrong");
endmodule : adcp_power_ctrl_checker

bind adcp_power_ctrl adcp_power_ctrl_checker #(.CONV_DIV(CONV_DIV), .STEPS(STEPS)) chk_u (
    .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
    .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .shutdown_pin_n(shutdown_pin_n),
    .acquire_o(acquire_o), .convert_busy_o(convert_busy_o),
    .standby_power_down_o(standby_power_down_o), .full_power_down_o(full_power_down_o),
    .bandgap_en_o(bandgap_en_o), .ref_buffer_en_o(ref_buffer_en_o), .analog_en_o(analog_en_o)
);

// ---- testbench/adcp_link_master.sv ----
// Purpose: behavioural two-wire bus master framing writes and reads toward the converter
// Assumes: link clock period 125 ns, both lines pulled up when released
// Notes: the slave never drives data here, so acknowledge bits read as released high
`timescale 1ns/100ps

module adcp_link_master (
    output logic scl_o,
    output logic sda_o
);
    // clock stands high between frames
    initial begin
        scl_o = 1'h1;
        sda_o = 1'h1;
    end

    task automatic put_bit(input logic b);
        scl_o = 1'h0;
        #25;
        sda_o = b;
        #37.5;
        scl_o = 1'h1;
        #62.5;
    endtask : put_bit

    task automatic frame(input logic [6:0] slv, input logic rw);
        sda_o = 1'h0;
        #62.5;
        for (int i = 6; i >= 0; i--) begin
            put_bit(slv[i]);
        end
        put_bit(rw);
        put_bit(1'h1);
        for (int i = 7; i >= 0; i--) begin
            put_bit(i == 7);
        end
        put_bit(1'h1);
        scl_o = 1'h0;
        #25;
        sda_o = 1'h0;
        #37.5;
        scl_o = 1'h1;
        #31.25;
        sda_o = 1'h1;
        #31.25;
    endtask : frame
endmodule : adcp_link_master

// ---- testbench/tb.sv ----
// Purpose: self-checking bench of the converter power-down and coding control
// Assumes: short conversion divider, link frames from the behavioural master
// Notes: the control byte goes over the register port; the link only frames and wakes
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin n_errors++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module tb;
    localparam int unsigned CDIV = 4;
    // reference recovery after full power-down, shortened for simulation
    localparam int REC_CYC = 100;
    localparam logic [6:0] SLV = {adcp_pkg::SLAVE_ADDR_HI, 3'h3};
    logic clk = 1'h0;
    logic reset_n = 1'h0;
    logic wr_en = 1'h0;
    logic rd_en = 1'h0;
    logic shutdown_pin_n_n = 1'h1;
    logic [3:0] addr = 4'h0;
    logic [2:0] apin = 3'h3;
    logic [31:0] wdata = 32'h0;
    logic [11:0] raw = 12'h000;
    logic [31:0] rdata;
    logic [2:0] ch;
    logic range_select, bipolar_select, acq, busy, stby, full, bg, refb, ana, scl, sda;
    logic [7:0] ctrl;
    logic [1:0] mode;
    logic [4:0] pwr_exp;
    logic [11:0] res;
    int n_errors = 0;
    int checks = 0;
    logic [1:0] pds [5] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3};
    logic [11:0] raws [5] = '{12'h000, 12'hFFF, 12'h800, 12'h7FF, 12'h123};

    always #2.5 clk = ~clk;

    adcp_power_ctrl #(.CONV_DIV(CDIV), .STEPS(adcp_pkg::CONV_STEPS)) dut_u (
        .core_clk_i(clk), .reset_n_i(reset_n), .addr_i(addr), .wr_data_i(wdata),
        .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rdata), .scl_i(scl), .sda_i(sda),
        .addr_pin_i(apin), .shutdown_pin_n(shutdown_pin_n_n), .raw_sample_i(raw), .channel_sel_o(ch),
        .range_select_o(range_select), .bipolar_select_o(bipolar_select), .acquire_o(acq), .convert_busy_o(busy),
        .standby_power_down_o(stby), .full_power_down_o(full), .bandgap_en_o(bg),
        .ref_buffer_en_o(refb), .analog_en_o(ana)
    );

    adcp_link_master m_u (.scl_o(scl), .sda_o(sda));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr_en <= 1'h1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_en <= 1'h0;
    endtask : reg_wr

    task automatic reg_rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd_en <= 1'h1;
        addr <= a;
        @(posedge clk);
        rd_en <= 1'h0;
        #1;
        `CHK(rdata, e)
    endtask : reg_rd

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wait_busy(input logic v);
        int k;
        k = 0;
        while (busy !== v && k < 2000) begin
            settle(1);
            k++;
        end
        `CHK(busy, v)
    endtask : wait_busy

    task automatic results;
        $display("n_errors=%0d checks=%0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // watchdog: nine link frames of about 2.4 us each, with margin
    // ------------------------------------------------------------
    initial begin
        #200000;
        n_errors++;
        results();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clk);
        reset_n <= 1'h1;
        reg_rd(adcp_pkg::REG_CTRL, 32'h0);
        reg_rd(adcp_pkg::REG_RESULT, 32'h0);
        reg_rd(adcp_pkg::REG_STATUS, 32'h0);
        `CHK({stby, full, ana, refb, bg}, 5'h07)
        for (int i = 0; i < 5; i++) begin
            ctrl = {1'h0, 3'(7 - i), i[1], i[0], pds[i]};
            @(posedge clk);
            raw <= raws[i];
            reg_wr(adcp_pkg::REG_CTRL, {24'h0, ctrl});
            #1;
            `CHK({acq, ch, range_select, bipolar_select}, {1'h1, ctrl[6:2]})
            m_u.frame(SLV, 1'h0);
            wait_busy(1'h1);
            `CHK({stby, full}, 2'h0)
            wait_busy(1'h0);
            res = ctrl[2] ? raws[i] ^ 12'h800 : raws[i];
            mode = pds[i][1] ? (pds[i][0] ? 2'h2 : 2'h1) : 2'h0;
            pwr_exp = {mode == 2'h1, mode == 2'h2, mode == 2'h0, mode != 2'h2, 1'h1};
            `CHK({stby, full, ana, refb, bg}, pwr_exp)
            reg_rd(adcp_pkg::REG_RESULT, {20'h0, res});
            reg_rd(adcp_pkg::REG_STATUS, {30'h0, mode});
        end
        m_u.frame(SLV ^ 7'h01, 1'h0);
        settle(8);
        `CHK(full, 1'h1)
        m_u.frame(SLV, 1'h1);
        settle(8);
        `CHK(full, 1'h1)
        // new pin address: only the frame that matches it may wake
        @(posedge clk);
        apin <= 3'h2;
        m_u.frame(SLV ^ 7'h01, 1'h0);
        settle(8);
        `CHK({full, refb, ana}, 3'h3)
        settle(REC_CYC);
        reg_wr(adcp_pkg::REG_CTRL, 32'h0000_0002);
        m_u.frame(SLV, 1'h0);
        wait_busy(1'h1);
        settle(10);
        @(posedge clk);
        shutdown_pin_n_n <= 1'h0;
        raw <= 12'hABC;
        settle(5);
        `CHK({full, stby, busy, acq, refb}, 5'h10)
        reg_rd(adcp_pkg::REG_RESULT, {20'h0, res});
        reg_rd(adcp_pkg::REG_STATUS, 32'h0000_0012);
        reg_wr(adcp_pkg::REG_CTRL, 32'h0000_0006);
        #1;
        `CHK(acq, 1'h0)
        @(posedge clk);
        shutdown_pin_n_n <= 1'h1;
        settle(6);
        `CHK({full, stby, ana, acq, busy}, 5'h04)
        reg_rd(adcp_pkg::REG_STATUS, 32'h0);
        reg_rd(4'hC, 32'h0);
        reg_wr(adcp_pkg::REG_RESULT, 32'h0000_0FFF);
        reg_rd(adcp_pkg::REG_RESULT, {20'h0, res});
        results();
    end
endmodule : tb
